// >>> logic/mab_pkg.sv
// Shared constants, types and timing for the muxed converter bus interface
package mab_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int IDX_W = 4;
	localparam int SEL_W = 9;
	localparam int CNT_W = 16;

	// Select vector position of the analog ground return
	localparam logic [IDX_W-1:0] GND_IDX = 4'h8;

	// Address field positions: channel bits, then the two mode bits
	localparam int ADDR_CH_LSB = 0;
	localparam int ADDR_MODE_LO = 3;
	localparam int ADDR_MODE_HI = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [ADDR_W-1:0] MUX_ADDR_RST = 5'h00;
	localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
	localparam logic [DATA_W-1:0] TRIAL_MSB = 8'h80;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int T_CONV_MAX_NS = 40000;
	localparam int T_CONV_DESIGN_NS = 60000;
	// Longest time: integer division rounds down
	localparam int CONV_CYC = T_CONV_MAX_NS / CLK_PERIOD_NS;
	// Eight bit decisions plus one slot of margin for load and flag
	localparam int SAR_SLOTS = 9;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		MODE_DIFF = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_PSEUDO = 2'b11
	} mab_mode_t;

	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} mab_strobe_t;

	// Bit k is channel k, bit 8 is analog ground
	typedef struct packed {
		logic [SEL_W-1:0] pos;
		logic [SEL_W-1:0] neg;
	} mab_sel_t;

endpackage : mab_pkg

// >>> logic/mab_mux_decode.sv
// Address latch decode into positive and negative input selects
`timescale 1ns/1ps
module mab_mux_decode import mab_pkg::*; #(
	parameter int NUM_CH = 8
) (
	// Clock for the checks only
	input wire logic clk,
	input wire logic reset,
	// Latched address
	input wire logic [ADDR_W-1:0] addr,
	// Decoded selection
	output mab_sel_t sel,
	output mab_mode_t mode
);

	function automatic logic [SEL_W-1:0] onehot(input logic [IDX_W-1:0] idx);
		onehot = 9'h001 << idx;
	endfunction : onehot

	localparam logic [2:0] CH_MASK = 3'(NUM_CH - 1);
	localparam logic [IDX_W-1:0] LAST_IDX = 4'(NUM_CH - 1);

	wire [2:0] ch = addr[ADDR_CH_LSB +: 3] & CH_MASK;
	wire [IDX_W-1:0] ch_idx = {1'b0, ch};
	wire [IDX_W-1:0] pair_pos = {1'b0, ch[2:1], ch[0]};
	wire [IDX_W-1:0] pair_neg = {1'b0, ch[2:1], ~ch[0]};

	// Upper address bit is a don't-care in differential mode
	assign mode = !addr[ADDR_MODE_LO] ? MODE_DIFF :
		(addr[ADDR_MODE_HI] ? MODE_PSEUDO : MODE_SINGLE);

	always_comb begin
		sel.pos = onehot(ch_idx);
		sel.neg = onehot(GND_IDX);
		unique case (mode)
			MODE_DIFF: begin
				sel.pos = onehot(pair_pos);
				sel.neg = onehot(pair_neg);
			end
			MODE_SINGLE: begin
				sel.neg = onehot(GND_IDX);
			end
			MODE_PSEUDO: begin
				sel.neg = onehot(LAST_IDX);
			end
		endcase
	end

	property p_diff_pair;
		@(posedge clk) disable iff (reset)
		mode == MODE_DIFF |-> ((sel.pos | sel.neg) == (9'h003 << {ch[2:1], 1'b0}))
			&& sel.pos[ch];
	endproperty
	a_diff_pair: assert property (p_diff_pair) else $error("pair select wrong");

	property p_ground_neg;
		@(posedge clk) disable iff (reset)
		mode == MODE_SINGLE |-> sel.neg[GND_IDX] && sel.pos[ch] && !sel.pos[GND_IDX];
	endproperty
	a_ground_neg: assert property (p_ground_neg) else $error("ground return wrong");

endmodule : mab_mux_decode

// >>> logic/mab_sar.sv
// Successive approximation engine with its conversion step divider
`timescale 1ns/1ps
module mab_sar import mab_pkg::*; #(
	parameter int CONV_CYCLES = CONV_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic cmp_hi,
	// Trial code and result
	output logic [DATA_W-1:0] trial,
	output logic [DATA_W-1:0] code,
	output logic busy,
	output logic done
);

	localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(CONV_CYCLES / SAR_SLOTS - 1);

	logic [CNT_W-1:0] step_cnt_ff;
	logic [CNT_W-1:0] busy_cnt_ff;
	logic [2:0] bit_ff;
	logic [DATA_W-1:0] trial_ff;
	logic [DATA_W-1:0] code_ff;
	logic busy_ff;
	logic done_ff;

	wire step_en = busy_ff && (step_cnt_ff == STEP_LAST);
	wire [DATA_W-1:0] bit_mask = 8'h01 << bit_ff;
	// A low comparator drops the trial bit; neg at or above pos ends at zero
	wire [DATA_W-1:0] kept = cmp_hi ? trial_ff : (trial_ff & ~bit_mask);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			step_cnt_ff <= '0;
			bit_ff <= 3'h7;
			trial_ff <= TRIAL_MSB;
			code_ff <= RESULT_RST;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				// A new start aborts any conversion still running
				step_cnt_ff <= '0;
				bit_ff <= 3'h7;
				trial_ff <= TRIAL_MSB;
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				step_cnt_ff <= step_en ? '0 : step_cnt_ff + 16'h0001;
				if (step_en) begin
					if (bit_ff == 3'h0) begin
						code_ff <= kept;
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
					end else begin
						trial_ff <= kept | (bit_mask >> 1);
						bit_ff <= bit_ff - 3'h1;
					end
				end
			end
		end
	end

	assign trial = trial_ff;
	assign code = code_ff;
	assign busy = busy_ff;
	assign done = done_ff;

	// Helper: cycles since the current conversion began
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy_cnt_ff <= '0;
		end else begin
			busy_cnt_ff <= (start || !busy_ff) ? '0 : busy_cnt_ff + 16'h0001;
		end
	end

	property p_conv_bound;
		@(posedge clk) disable iff (reset)
		busy_ff |-> busy_cnt_ff < CNT_W'(CONV_CYCLES);
	endproperty
	a_conv_bound: assert property (p_conv_bound) else $error("conversion too long");

	property p_done_pulse;
		@(posedge clk) disable iff (reset)
		done_ff |-> !busy_ff ##1 !done_ff;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");

endmodule : mab_sar

// >>> logic/mab_adc_ctrl.sv
// Host strobe interface, address latch and completion flag of the converter
`timescale 1ns/1ps
module mab_adc_ctrl import mab_pkg::*; #(
	parameter int NUM_CH = 8,
	parameter int CONV_CYCLES = CONV_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Host strobes, active low, asynchronous
	input wire mab_strobe_t host_strobe_n,
	// Shared low data lines seen as address
	input wire logic [ADDR_W-1:0] mux_select_bits,
	// Result bus drive
	output logic [DATA_W-1:0] result_bus_out,
	output logic result_bus_oe_n,
	// Completion flag
	output logic conv_done_n,
	// Analog front end
	output mab_sel_t input_selector,
	output mab_mode_t selector_mode,
	output logic [DATA_W-1:0] dac_trial,
	input wire logic cmp_hi
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	localparam int SYNC_W = ADDR_W + 4;

	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;

	wire [SYNC_W-1:0] sync_raw = {cmp_hi, mux_select_bits, host_strobe_n};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_ff <= {1'b0, MUX_ADDR_RST, 3'h7};
			sync2_ff <= {1'b0, MUX_ADDR_RST, 3'h7};
		end else begin
			sync1_ff <= sync_raw;
			sync2_ff <= sync1_ff;
		end
	end

	mab_strobe_t strb_q;
	wire [ADDR_W-1:0] addr_q = sync2_ff[3 +: ADDR_W];
	wire cmp_q = sync2_ff[SYNC_W-1];

	assign strb_q = sync2_ff[2:0];

	////////////////////////////////////////////////////////////////////////////////
	// Strobe decode

	logic wr_act_d_ff;
	logic rd_low_whole_ff;

	// A write only counts while chip select is low
	wire wr_act = !strb_q.cs_n && !strb_q.wr_n;
	wire rd_act = !strb_q.cs_n && !strb_q.rd_n;
	wire wr_start = wr_act && !wr_act_d_ff;
	wire wr_end = !wr_act && wr_act_d_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_act_d_ff <= 1'b0;
		end else begin
			wr_act_d_ff <= wr_act;
		end
	end

	// Tracks whether read stayed low over the entire write pulse
	wire nxt_rd_low_whole = wr_start ? !strb_q.rd_n :
		(wr_act ? (rd_low_whole_ff && !strb_q.rd_n) : rd_low_whole_ff);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_low_whole_ff <= 1'b0;
		end else begin
			rd_low_whole_ff <= nxt_rd_low_whole;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address latch

	logic [ADDR_W-1:0] mux_addr_ff;

	// Address lines are only sampled with read high; otherwise keep the old setup
	wire addr_load = wr_end && strb_q.rd_n;
	wire [ADDR_W-1:0] nxt_mux_addr = addr_load ? addr_q : mux_addr_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mux_addr_ff <= MUX_ADDR_RST;
		end else begin
			mux_addr_ff <= nxt_mux_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Selector decode and conversion engine

	mab_sel_t dec_sel;
	mab_sel_t sel_ff;
	mab_mode_t dec_mode;
	mab_mode_t mode_ff;

	mab_mux_decode #(
		.NUM_CH(NUM_CH)
	) u_decode (
		.clk(clk),
		.reset(reset),
		.addr(mux_addr_ff),
		.sel(dec_sel),
		.mode(dec_mode)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sel_ff <= '0;
			mode_ff <= MODE_DIFF;
		end else begin
			sel_ff <= dec_sel;
			mode_ff <= dec_mode;
		end
	end

	assign input_selector = sel_ff;
	assign selector_mode = mode_ff;

	logic [DATA_W-1:0] sar_trial;
	logic [DATA_W-1:0] sar_code;
	logic sar_busy;
	logic sar_done;

	// Both write endings start a conversion, with new or retained setup
	mab_sar #(
		.CONV_CYCLES(CONV_CYCLES)
	) u_sar (
		.clk(clk),
		.reset(reset),
		.start(wr_end),
		.cmp_hi(cmp_q),
		.trial(sar_trial),
		.code(sar_code),
		.busy(sar_busy),
		.done(sar_done)
	);

	assign dac_trial = sar_trial;

	////////////////////////////////////////////////////////////////////////////////
	// Output latch and completion flag

	logic [DATA_W-1:0] result_ff;
	logic done_pend_ff;
	logic done_n_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_ff <= RESULT_RST;
			done_pend_ff <= 1'b0;
		end else begin
			if (sar_done) begin
				result_ff <= sar_code;
			end
			done_pend_ff <= sar_done;
		end
	end

	// Completion lands one cycle after the latch, and beats a same-cycle clear
	wire nxt_done_n = done_pend_ff ? 1'b0 :
		((rd_act || wr_start) ? 1'b1 : done_n_ff);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			done_n_ff <= 1'b1;
		end else begin
			done_n_ff <= nxt_done_n;
		end
	end

	assign conv_done_n = done_n_ff;

	// Drive follows the synchronised strobes, so release lags read by two cycles
	assign result_bus_oe_n = !rd_act;
	assign result_bus_out = result_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_read_raises;
		@(posedge clk) disable iff (reset)
		rd_act && !done_pend_ff |-> !result_bus_oe_n ##1 conv_done_n;
	endproperty
	a_read_raises: assert property (p_read_raises) else $error("read did not raise flag");

	property p_wr_raises;
		@(posedge clk) disable iff (reset)
		wr_start && !done_pend_ff |=> conv_done_n;
	endproperty
	a_wr_raises: assert property (p_wr_raises) else $error("write did not raise flag");

	property p_result_then_flag;
		@(posedge clk) disable iff (reset)
		sar_done |=> (result_ff == $past(sar_code)) ##1 !conv_done_n;
	endproperty
	a_result_then_flag: assert property (p_result_then_flag) else $error("result order");

	property p_flag_holds;
		@(posedge clk) disable iff (reset)
		!conv_done_n && !rd_act && !wr_start |=> !conv_done_n;
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("flag left before read");

	property p_release;
		@(posedge clk) disable iff (reset)
		$rose(strb_q.rd_n) |-> result_bus_oe_n;
	endproperty
	a_release: assert property (p_release) else $error("bus not released");

	property p_addr_latch;
		@(posedge clk) disable iff (reset)
		wr_end && strb_q.rd_n |=> (mux_addr_ff == $past(addr_q)) && sar_busy;
	endproperty
	a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

	property p_addr_keep;
		@(posedge clk) disable iff (reset)
		wr_end && rd_low_whole_ff && !strb_q.rd_n |=> $stable(mux_addr_ff) && sar_busy;
	endproperty
	a_addr_keep: assert property (p_addr_keep) else $error("setup not kept");

	property p_select_follows;
		@(posedge clk) disable iff (reset)
		addr_load |=> ##1 (input_selector == $past(dec_sel));
	endproperty
	a_select_follows: assert property (p_select_follows) else $error("select stale");

endmodule : mab_adc_ctrl

// >>> tb/mab_host_model.sv
// Host bus and analog source model facing the converter control block
`timescale 1ns/1ps
module mab_host_model import mab_pkg::*; (
	// Clock
	input wire logic clk,
	// Host side
	output mab_strobe_t host_strobe_n,
	output logic [ADDR_W-1:0] mux_select_bits,
	// Analog side
	input wire logic [8:0][7:0] vin,
	input wire mab_sel_t input_selector,
	input wire logic [DATA_W-1:0] dac_trial,
	output logic cmp_hi
);
	int pv;
	int nv;
	initial begin
		host_strobe_n = '1;
		mux_select_bits = '0;
		cmp_hi = 1'b0;
	end
	////////////////////////////////
	// A tie keeps the bit, so a negative input at or above the positive ends at zero
	always @(posedge clk) begin
		pv = 0;
		nv = 0;
		for (int k = 0; k < SEL_W; k++) begin
			if (input_selector.pos[k]) pv = vin[k];
			if (input_selector.neg[k]) nv = vin[k];
		end
		cmp_hi <= (pv - nv) >= int'(dac_trial);
	end
	////////////////////////////////
	// Pulse is well above the minimum width so the synchroniser never misses it
	task automatic write_cycle(input logic [ADDR_W-1:0] a, input logic rd_low);
		host_strobe_n <= '{cs_n: 1'b0, wr_n: 1'b0, rd_n: ~rd_low};
		mux_select_bits <= a;
		repeat (32) @(posedge clk);
		host_strobe_n.wr_n <= 1'b1;
		@(posedge clk);
		host_strobe_n <= '1;
		// Released lines must not keep showing the address after hold time
		fork
			begin
				repeat (10) @(posedge clk);
				mux_select_bits <= ~a;
			end
		join_none
	endtask : write_cycle
	task automatic read_cycle();
		// Callers may arrive just after an edge; strobes only move on one
		@(posedge clk);
		host_strobe_n <= '{cs_n: 1'b0, wr_n: 1'b1, rd_n: 1'b0};
		repeat (8) @(posedge clk);
		host_strobe_n <= '1;
		@(posedge clk);
	endtask : read_cycle
endmodule : mab_host_model

// >>> tb/mab_adc_ctrl_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module mab_adc_ctrl_tb_top import mab_pkg::*;;
	// Short conversion: ten cycles a step
	localparam int CONV_SIM = 90;
	localparam int RD_GAP = 600 / CLK_PERIOD_NS;
	localparam logic [4:0] ADDRS [12] = '{5'h00, 5'h01, 5'h02, 5'h07, 5'h08, 5'h0B,
		5'h0F, 5'h10, 5'h15, 5'h18, 5'h1A, 5'h1E};
	logic clk;
	logic reset;
	logic [8:0][7:0] vin;
	mab_strobe_t host_strobe_n;
	logic [ADDR_W-1:0] mux_select_bits;
	logic [DATA_W-1:0] result_bus_out;
	logic result_bus_oe_n;
	logic conv_done_n;
	mab_sel_t input_selector;
	mab_mode_t selector_mode;
	logic [DATA_W-1:0] dac_trial;
	logic cmp_hi;
	logic [31:0] lfsr;
	logic [DATA_W-1:0] exp_q[$];
	logic [DATA_W-1:0] last_code;
	logic oe_q;
	int num_errors;
	int checked;
	int cycles;
	int wait_cnt;

	mab_adc_ctrl #(.NUM_CH(8), .CONV_CYCLES(CONV_SIM)) u_mab_adc_ctrl (
		.clk(clk), .reset(reset), .host_strobe_n(host_strobe_n),
		.mux_select_bits(mux_select_bits), .result_bus_out(result_bus_out),
		.result_bus_oe_n(result_bus_oe_n), .conv_done_n(conv_done_n),
		.input_selector(input_selector), .selector_mode(selector_mode),
		.dac_trial(dac_trial), .cmp_hi(cmp_hi));
	mab_host_model u_mab_host_model (
		.clk(clk), .host_strobe_n(host_strobe_n), .mux_select_bits(mux_select_bits),
		.vin(vin), .input_selector(input_selector), .dac_trial(dac_trial),
		.cmp_hi(cmp_hi));

	////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// Sample one step after the edge so registered outputs have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	function automatic int neg_idx(input logic [4:0] a);
		if (!a[3]) return {a[2:1], ~a[0]};
		return a[4] ? 7 : 8;
	endfunction : neg_idx
	function automatic mab_sel_t exp_sel(input logic [4:0] a);
		mab_sel_t s;
		s = '0;
		s.pos[a[2:0]] = 1'b1;
		s.neg[neg_idx(a)] = 1'b1;
		return s;
	endfunction : exp_sel
	function automatic mab_mode_t exp_mode(input logic [4:0] a);
		return !a[3] ? MODE_DIFF : (a[4] ? MODE_PSEUDO : MODE_SINGLE);
	endfunction : exp_mode
	function automatic logic [7:0] exp_code(input logic [4:0] a);
		int d;
		d = int'(vin[a[2:0]]) - int'(vin[neg_idx(a)]);
		return (d > 0) ? d[7:0] : 8'h00;
	endfunction : exp_code
	task automatic convert(input logic [4:0] a, input logic rd_low, input logic [4:0] ea);
		fork
			u_mab_host_model.write_cycle(a, rd_low);
			begin
				tick(20);
				check("flag during write", 32'h1, conv_done_n);
			end
		join
		wait_cnt = 0;
		while (conv_done_n !== 1'b0 && wait_cnt < CONV_SIM + 16) begin
			tick(1);
			wait_cnt++;
		end
		check("conversion done in time", 32'h0, conv_done_n);
		check("selector", exp_sel(ea), input_selector);
		check("mode", exp_mode(ea), selector_mode);
	endtask : convert
	task automatic read_check();
		fork
			u_mab_host_model.read_cycle();
			begin
				tick(5);
				check("flag during read", 32'h1, conv_done_n);
			end
		join
		tick(3);
		check("bus released", 32'h1, result_bus_oe_n);
	endtask : read_check
	task automatic new_inputs(input int i);
		@(posedge clk);
		for (int k = 0; k < 8; k++) begin
			lfsr = lfsr_next(lfsr);
			vin[k] <= (i == 3) ? 8'h5A : lfsr[7:0];
		end
		@(posedge clk);
	endtask : new_inputs

	////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Each result drive takes the oldest noted value
	always @(negedge clk) begin
		oe_q <= result_bus_oe_n;
		if (!reset && oe_q === 1'b1 && result_bus_oe_n === 1'b0) begin
			if (exp_q.size() == 0) check("unexpected drive", 32'h1, 32'h0);
			else check("result", exp_q.pop_front(), result_bus_out);
		end
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		reset = 1'b1;
		vin = '0;
		lfsr = 32'h99403995;
		oe_q = 1'b1;
		num_errors = 0;
		checked = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		tick(3);
		check("reset flag", 32'h1, conv_done_n);
		check("reset bus", 32'h1, result_bus_oe_n);
		check("reset trial", TRIAL_MSB, dac_trial);
		$display("test reset done");
		// Every third result is left unread so the next write must clear the flag
		for (int i = 0; i < 12; i++) begin
			new_inputs(i);
			convert(ADDRS[i], 1'b0, ADDRS[i]);
			last_code = exp_code(ADDRS[i]);
			tick(RD_GAP);
			check("flag held until read", 32'h0, conv_done_n);
			if (i % 3 != 2) begin
				exp_q.push_back(last_code);
				read_check();
			end
			$display("test mode_%0d done", i);
		end
		new_inputs(0);
		exp_q.push_back(last_code);
		convert(5'h03, 1'b1, ADDRS[11]);
		exp_q.push_back(exp_code(ADDRS[11]));
		tick(RD_GAP);
		read_check();
		check("all results read", 32'h0, exp_q.size());
		$display("test read_during_write done");
		tally_and_finish();
	end
endmodule : mab_adc_ctrl_tb_top
